// ==== verilog/oag_top.sv ====
// Operand effective address generation with working register file and split X and Y prefetch generators.
// ------------------------------------------------------------
// How it works
// - File direct takes address from instruction field.
// - Register direct uses register contents, no address.
// - Indirect uses base pointer as address.
// - Post-modify: access at pointer, then step it.
// - Pre-modify: step pointer first, then access.
// - Indexed address is base plus offset register.
// - Literal offset address is base plus literal.
// - Move and accumulator classes also allow indexed.
// - Move: separate modes, one shared offset field.
// - Move allows listed modes, accum all but file direct; both add 8/16-bit literals.
// - General and accumulator classes check which modes are legal; move accepts every mode.
// - Dual-source ops decode only four prefetch pointers.
// - First two to X, last two to Y.
// - Prefetch indexed only on second X, Y pointer.
// - Prefetch modes: indirect, indexed, post-modify 2/4/6.
// - Branch target is 16-bit signed literal.
// - Interrupt disable takes 14-bit unsigned literal.
// - Unlink uses implied registers; no-op has none.
// ------------------------------------------------------------
`timescale 1ns/1ps

module oag_top #(
    parameter int DATA_W = oag_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    // Decoded instruction
    input  wire logic                  instr_valid_i,
    input  wire logic [2:0]            instr_class_i,
    input  wire logic [3:0]            src_mode_i,
    input  wire logic [3:0]            src_reg_i,
    input  wire logic [3:0]            dst_mode_i,
    input  wire logic [3:0]            dst_reg_i,
    input  wire logic [3:0]            offset_reg_i,
    input  wire logic                  mod_dec_i,
    input  wire logic [DATA_W-1:0]     literal_i,
    input  wire logic [DATA_W-1:0]     file_addr_i,
    // Prefetch fields for dual-source operations
    input  wire logic [3:0]            x_ptr_i,
    input  wire logic [2:0]            x_pf_mode_i,
    input  wire logic [3:0]            y_ptr_i,
    input  wire logic [2:0]            y_pf_mode_i,
    // Result writeback from the execution unit
    input  wire logic                  wb_en_i,
    input  wire logic [3:0]            wb_reg_i,
    input  wire logic [DATA_W-1:0]     wb_data_i,
    // Source and destination operand outputs
    output logic                       src_mem_o,
    output logic [DATA_W-1:0]          src_addr_o,
    output logic [DATA_W-1:0]          src_data_o,
    output logic                       dst_mem_o,
    output logic [DATA_W-1:0]          dst_addr_o,
    output logic [3:0]                 dst_reg_o,
    // Prefetch generator outputs
    output logic                       x_rd_en_o,
    output logic [DATA_W-1:0]          x_rd_addr_o,
    output logic                       y_rd_en_o,
    output logic [DATA_W-1:0]          y_rd_addr_o,
    // Status
    output logic                       op_done_o,
    output logic                       mode_err_o
);

    // ------------------------------------------------------------
    // Legal mode check per class
    // ------------------------------------------------------------
    function automatic logic mode_legal(input logic [2:0] cls, input logic [3:0] mode);
        logic ok;
        ok = 1'b0;
        if (mode == oag_pkg::AM_NONE) begin
            ok = 1'b1;
        end else if (cls == oag_pkg::OAG_CLS_MOVE || cls == oag_pkg::OAG_CLS_ACCUM) begin
            ok = (mode != oag_pkg::AM_FILE_DIRECT) || (cls == oag_pkg::OAG_CLS_MOVE);
        end else if (cls == oag_pkg::OAG_CLS_GENERAL) begin
            // Indexed and 8/16-bit literal forms are reserved for the richer classes.
            ok = (mode <= oag_pkg::AM_PRE_MOD) || (mode == oag_pkg::AM_LIT_OFFSET);
        end else begin
            ok = 1'b0;
        end
        return ok;
    endfunction : mode_legal

    // A prefetch pointer must be one of the four and belong to its own generator.
    function automatic logic pf_legal(input logic [3:0] ptr, input logic [2:0] mode, input logic is_y);
        logic ok;
        logic [3:0] ptr_a;
        logic [3:0] ptr_b;
        ok    = 1'b0;
        ptr_a = is_y ? oag_pkg::Y_PREFETCH_PTR_A : oag_pkg::X_PREFETCH_PTR_A;
        ptr_b = is_y ? oag_pkg::Y_PREFETCH_PTR_B : oag_pkg::X_PREFETCH_PTR_B;
        if (mode == oag_pkg::PF_NONE) begin
            ok = 1'b1;
        end else if (mode == oag_pkg::PF_INDEXED) begin
            ok = (ptr == ptr_b);
        end else if (mode <= oag_pkg::PF_POST_6) begin
            ok = (ptr == ptr_a) || (ptr == ptr_b);
        end
        return ok;
    endfunction : pf_legal

    function automatic logic [15:0] pf_step(input logic [2:0] mode);
        logic [15:0] s;
        s = 16'h0000;
        case (mode)
            oag_pkg::PF_POST_2: s = oag_pkg::PREFETCH_STEP_2;
            oag_pkg::PF_POST_4: s = oag_pkg::PREFETCH_STEP_4;
            oag_pkg::PF_POST_6: s = oag_pkg::PREFETCH_STEP_6;
            default:            s = 16'h0000;
        endcase
        return s;
    endfunction : pf_step

    // ------------------------------------------------------------
    // Working register file
    // ------------------------------------------------------------
    logic [DATA_W-1:0] regs_r   [oag_pkg::NUM_REGS];
    logic [DATA_W-1:0] regs_nxt [oag_pkg::NUM_REGS];

    // Output registers
    logic              src_mem_r,  src_mem_nxt;
    logic [DATA_W-1:0] src_addr_r, src_addr_nxt;
    logic [DATA_W-1:0] src_data_r, src_data_nxt;
    logic              dst_mem_r,  dst_mem_nxt;
    logic [DATA_W-1:0] dst_addr_r, dst_addr_nxt;
    logic [3:0]        dst_reg_r,  dst_reg_nxt;
    logic              x_en_r,     x_en_nxt;
    logic [DATA_W-1:0] x_addr_r,   x_addr_nxt;
    logic              y_en_r,     y_en_nxt;
    logic [DATA_W-1:0] y_addr_r,   y_addr_nxt;
    logic              done_r,     done_nxt;
    logic              err_r,      err_nxt;

    // ------------------------------------------------------------
    // Address generation
    // ------------------------------------------------------------
    // The step is one word for the post- and pre-modify operand modes; byte moves are not modelled here.
    localparam logic [DATA_W-1:0] WORD_STEP = DATA_W'(2);

    always_comb begin
        logic [DATA_W-1:0] base;
        logic [DATA_W-1:0] stepped;
        logic [DATA_W-1:0] ea;
        logic              legal;
        logic              is_mem;
        base    = '0;
        stepped = '0;
        ea      = '0;
        legal   = 1'b1;
        is_mem  = 1'b0;
        for (int i = 0; i < oag_pkg::NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        src_mem_nxt  = 1'b0;
        src_addr_nxt = src_addr_r;
        src_data_nxt = src_data_r;
        dst_mem_nxt  = 1'b0;
        dst_addr_nxt = dst_addr_r;
        dst_reg_nxt  = dst_reg_r;
        x_en_nxt     = 1'b0;
        x_addr_nxt   = x_addr_r;
        y_en_nxt     = 1'b0;
        y_addr_nxt   = y_addr_r;
        done_nxt     = 1'b0;
        err_nxt      = 1'b0;

        // Writeback goes first so a pointer update in the same cycle takes priority.
        if (wb_en_i) begin
            regs_nxt[wb_reg_i] = wb_data_i;
        end

        if (instr_valid_i) begin
            done_nxt = 1'b1;
            case (instr_class_i)
                oag_pkg::OAG_CLS_BRANCH: begin
                    src_data_nxt = literal_i;
                end
                oag_pkg::OAG_CLS_DISABLE: begin
                    src_data_nxt = {{(DATA_W-oag_pkg::DISABLE_LIT_W){1'b0}},
                                    literal_i[oag_pkg::DISABLE_LIT_W-1:0]};
                end
                oag_pkg::OAG_CLS_UNLINK: begin
                    // Stack pointer takes the frame pointer; the old frame is then popped.
                    src_mem_nxt  = 1'b1;
                    src_addr_nxt = regs_r[oag_pkg::FRAME_PTR_IDX];
                    regs_nxt[oag_pkg::STACK_PTR_IDX] = regs_r[oag_pkg::FRAME_PTR_IDX];
                    dst_reg_nxt  = oag_pkg::FRAME_PTR_IDX;
                end
                oag_pkg::OAG_CLS_NOP: begin
                    done_nxt = 1'b1;
                end
                oag_pkg::OAG_CLS_MAC: begin
                    legal = pf_legal(x_ptr_i, x_pf_mode_i, 1'b0) && pf_legal(y_ptr_i, y_pf_mode_i, 1'b1);
                    if (legal) begin
                        if (x_pf_mode_i != oag_pkg::PF_NONE) begin
                            x_en_nxt   = 1'b1;
                            x_addr_nxt = (x_pf_mode_i == oag_pkg::PF_INDEXED) ?
                                         DATA_W'(regs_r[x_ptr_i] + regs_r[offset_reg_i]) : regs_r[x_ptr_i];
                            regs_nxt[x_ptr_i] = DATA_W'(regs_r[x_ptr_i] + pf_step(x_pf_mode_i));
                        end
                        if (y_pf_mode_i != oag_pkg::PF_NONE) begin
                            y_en_nxt   = 1'b1;
                            y_addr_nxt = (y_pf_mode_i == oag_pkg::PF_INDEXED) ?
                                         DATA_W'(regs_r[y_ptr_i] + regs_r[offset_reg_i]) : regs_r[y_ptr_i];
                            regs_nxt[y_ptr_i] = DATA_W'(regs_r[y_ptr_i] + pf_step(y_pf_mode_i));
                        end
                    end
                end
                default: begin
                    legal = mode_legal(instr_class_i, src_mode_i) &&
                            mode_legal(instr_class_i, dst_mode_i);
                    if (legal) begin
                        // Source operand.
                        base    = regs_r[src_reg_i];
                        stepped = mod_dec_i ? DATA_W'(base - WORD_STEP) : DATA_W'(base + WORD_STEP);
                        is_mem  = 1'b1;
                        ea      = base;
                        case (src_mode_i)
                            oag_pkg::AM_FILE_DIRECT: ea = file_addr_i;
                            oag_pkg::AM_REG_DIRECT: begin
                                is_mem       = 1'b0;
                                src_data_nxt = base;
                            end
                            oag_pkg::AM_INDIRECT:   ea = base;
                            oag_pkg::AM_POST_MOD: begin
                                ea = base;
                                regs_nxt[src_reg_i] = stepped;
                            end
                            oag_pkg::AM_PRE_MOD: begin
                                ea = stepped;
                                regs_nxt[src_reg_i] = stepped;
                            end
                            oag_pkg::AM_INDEXED:    ea = DATA_W'(base + regs_r[offset_reg_i]);
                            oag_pkg::AM_LIT_OFFSET: ea = DATA_W'(base + literal_i);
                            oag_pkg::AM_LIT8: begin
                                is_mem       = 1'b0;
                                src_data_nxt = {{(DATA_W-oag_pkg::SHORT_LIT_W){1'b0}},
                                                literal_i[oag_pkg::SHORT_LIT_W-1:0]};
                            end
                            oag_pkg::AM_LIT16: begin
                                is_mem       = 1'b0;
                                src_data_nxt = literal_i;
                            end
                            default: is_mem = 1'b0;
                        endcase
                        src_mem_nxt = is_mem;
                        if (is_mem) begin
                            src_addr_nxt = ea;
                        end

                        // Destination operand, decoded independently of the source.
                        base        = regs_r[dst_reg_i];
                        stepped     = mod_dec_i ? DATA_W'(base - WORD_STEP) : DATA_W'(base + WORD_STEP);
                        dst_reg_nxt = dst_reg_i;
                        is_mem      = 1'b1;
                        ea          = base;
                        case (dst_mode_i)
                            oag_pkg::AM_FILE_DIRECT: ea = file_addr_i;
                            oag_pkg::AM_INDIRECT:    ea = base;
                            oag_pkg::AM_POST_MOD: begin
                                ea = base;
                                regs_nxt[dst_reg_i] = stepped;
                            end
                            oag_pkg::AM_PRE_MOD: begin
                                ea = stepped;
                                regs_nxt[dst_reg_i] = stepped;
                            end
                            oag_pkg::AM_INDEXED:    ea = DATA_W'(base + regs_r[offset_reg_i]);
                            oag_pkg::AM_LIT_OFFSET: ea = DATA_W'(base + literal_i);
                            default:                is_mem = 1'b0;
                        endcase
                        dst_mem_nxt = is_mem;
                        if (is_mem) begin
                            dst_addr_nxt = ea;
                        end
                    end
                end
            endcase
            if (!legal) begin
                done_nxt = 1'b0;
                err_nxt  = 1'b1;
                for (int i = 0; i < oag_pkg::NUM_REGS; i++) begin
                    regs_nxt[i] = regs_r[i];
                end
                if (wb_en_i) begin
                    regs_nxt[wb_reg_i] = wb_data_i;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < oag_pkg::NUM_REGS; i++) begin
                regs_r[i] <= oag_pkg::REG_RESET_VAL;
            end
            src_mem_r  <= 1'b0;
            src_addr_r <= oag_pkg::REG_RESET_VAL;
            src_data_r <= oag_pkg::REG_RESET_VAL;
            dst_mem_r  <= 1'b0;
            dst_addr_r <= oag_pkg::REG_RESET_VAL;
            dst_reg_r  <= 4'h0;
            x_en_r     <= 1'b0;
            x_addr_r   <= oag_pkg::REG_RESET_VAL;
            y_en_r     <= 1'b0;
            y_addr_r   <= oag_pkg::REG_RESET_VAL;
            done_r     <= 1'b0;
            err_r      <= 1'b0;
        end else begin
            for (int i = 0; i < oag_pkg::NUM_REGS; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
            src_mem_r  <= src_mem_nxt;
            src_addr_r <= src_addr_nxt;
            src_data_r <= src_data_nxt;
            dst_mem_r  <= dst_mem_nxt;
            dst_addr_r <= dst_addr_nxt;
            dst_reg_r  <= dst_reg_nxt;
            x_en_r     <= x_en_nxt;
            x_addr_r   <= x_addr_nxt;
            y_en_r     <= y_en_nxt;
            y_addr_r   <= y_addr_nxt;
            done_r     <= done_nxt;
            err_r      <= err_nxt;
        end
    end

    assign src_mem_o   = src_mem_r;
    assign src_addr_o  = src_addr_r;
    assign src_data_o  = src_data_r;
    assign dst_mem_o   = dst_mem_r;
    assign dst_addr_o  = dst_addr_r;
    assign dst_reg_o   = dst_reg_r;
    assign x_rd_en_o   = x_en_r;
    assign x_rd_addr_o = x_addr_r;
    assign y_rd_en_o   = y_en_r;
    assign y_rd_addr_o = y_addr_r;
    assign op_done_o   = done_r;
    assign mode_err_o  = err_r;

endmodule : oag_top

// ==== verilog/oag_pkg.sv ====
// Package for the operand address generation block: widths, encodings and reset values.
package oag_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W        = 16;
    localparam int REG_IDX_W     = 4;
    localparam int NUM_REGS      = 16;
    localparam int BRANCH_LIT_W  = 16;
    localparam int DISABLE_LIT_W = 14;
    localparam int SHORT_LIT_W   = 8;

    // ------------------------------------------------------------
    // Prefetch pointer register indices
    // ------------------------------------------------------------
    localparam logic [3:0] X_PREFETCH_PTR_A = 4'h8;
    localparam logic [3:0] X_PREFETCH_PTR_B = 4'h9;
    localparam logic [3:0] Y_PREFETCH_PTR_A = 4'hA;
    localparam logic [3:0] Y_PREFETCH_PTR_B = 4'hB;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RESET_VAL = 16'h0000;

    // ------------------------------------------------------------
    // Prefetch post-modify amounts
    // ------------------------------------------------------------
    localparam logic [15:0] PREFETCH_STEP_2 = 16'h0002;
    localparam logic [15:0] PREFETCH_STEP_4 = 16'h0004;
    localparam logic [15:0] PREFETCH_STEP_6 = 16'h0006;

    // ------------------------------------------------------------
    // Addressing mode encodings
    // ------------------------------------------------------------
    localparam logic [3:0] AM_FILE_DIRECT = 4'h0;
    localparam logic [3:0] AM_REG_DIRECT  = 4'h1;
    localparam logic [3:0] AM_INDIRECT    = 4'h2;
    localparam logic [3:0] AM_POST_MOD    = 4'h3;
    localparam logic [3:0] AM_PRE_MOD     = 4'h4;
    localparam logic [3:0] AM_INDEXED     = 4'h5;
    localparam logic [3:0] AM_LIT_OFFSET  = 4'h6;
    localparam logic [3:0] AM_LIT8        = 4'h7;
    localparam logic [3:0] AM_LIT16       = 4'h8;
    localparam logic [3:0] AM_NONE        = 4'hF;

    // ------------------------------------------------------------
    // Prefetch mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] PF_NONE     = 3'h0;
    localparam logic [2:0] PF_INDIRECT = 3'h1;
    localparam logic [2:0] PF_POST_2   = 3'h2;
    localparam logic [2:0] PF_POST_4   = 3'h3;
    localparam logic [2:0] PF_POST_6   = 3'h4;
    localparam logic [2:0] PF_INDEXED  = 3'h5;

    // ------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OAG_CLS_GENERAL,
        OAG_CLS_MOVE,
        OAG_CLS_ACCUM,
        OAG_CLS_MAC,
        OAG_CLS_BRANCH,
        OAG_CLS_DISABLE,
        OAG_CLS_UNLINK,
        OAG_CLS_NOP
    } oag_class_t;

    // Frame unlink uses fixed registers: the frame pointer and the stack pointer.
    localparam logic [3:0] FRAME_PTR_IDX = 4'hE;
    localparam logic [3:0] STACK_PTR_IDX = 4'hF;

endpackage : oag_pkg

// ==== verification/oag_asserts.sv ====
// Checker for operand address generation, bound to the top module.
`timescale 1ns/1ps
module oag_asserts #(
    parameter int DATA_W = oag_pkg::DATA_W
) (
    // Clock, reset and instruction
    input wire logic              mclk_i,
    input wire logic              rst_n_i,
    input wire logic              instr_valid_i,
    input wire logic [2:0]        instr_class_i,
    input wire logic [3:0]        src_mode_i,
    input wire logic [3:0]        dst_mode_i,
    input wire logic [DATA_W-1:0] literal_i,
    input wire logic [DATA_W-1:0] file_addr_i,
    input wire logic [3:0]        x_ptr_i,
    input wire logic [2:0]        x_pf_mode_i,
    // Outputs watched
    input wire logic              src_mem_o,
    input wire logic [DATA_W-1:0] src_addr_o,
    input wire logic [DATA_W-1:0] src_data_o,
    input wire logic              dst_mem_o,
    input wire logic              x_rd_en_o,
    input wire logic              y_rd_en_o,
    input wire logic              op_done_o,
    input wire logic              mode_err_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic mac_v;
    assign mac_v = instr_valid_i && instr_class_i == oag_pkg::OAG_CLS_MAC;
    a_answer_once: assert property (instr_valid_i |=> op_done_o ^ mode_err_o)
        else $error("one answer per instruction missing");
    a_no_spurious: assert property ((op_done_o || mode_err_o) |-> $past(instr_valid_i))
        else $error("answer without instruction");
    a_err_quiet: assert property (mode_err_o |-> !(src_mem_o || dst_mem_o || x_rd_en_o || y_rd_en_o))
        else $error("refused instruction accessed memory");
    a_file_direct: assert property (instr_valid_i && instr_class_i == oag_pkg::OAG_CLS_GENERAL &&
        src_mode_i == oag_pkg::AM_FILE_DIRECT && dst_mode_i == oag_pkg::AM_NONE
        |=> src_mem_o && src_addr_o == $past(file_addr_i)) else $error("file address not used");
    a_branch_lit: assert property (instr_valid_i && instr_class_i == oag_pkg::OAG_CLS_BRANCH
        |=> src_data_o == $past(literal_i)) else $error("branch literal wrong");
    a_disable_lit: assert property (instr_valid_i && instr_class_i == oag_pkg::OAG_CLS_DISABLE
        |=> src_data_o == ($past(literal_i) & 16'h3FFF)) else $error("disable literal wrong");
    a_mac_pointer: assert property (mac_v && x_pf_mode_i != oag_pkg::PF_NONE && x_ptr_i[3:1] != 3'h4
        |=> mode_err_o) else $error("bad X prefetch pointer taken");
    a_mac_index: assert property (mac_v && x_pf_mode_i == oag_pkg::PF_INDEXED && x_ptr_i[0] == 1'b0
        |=> mode_err_o) else $error("indexed allowed on first X pointer");
    a_x_route: assert property (x_rd_en_o |-> $past(instr_class_i) == oag_pkg::OAG_CLS_MAC)
        else $error("X read outside dual-source operation");
endmodule : oag_asserts

bind oag_top oag_asserts #(.DATA_W(DATA_W)) i_chk (.*);

// ==== verification/oag_mem_model.sv ====
// X and Y data space model: counts prefetch reads and flags reads outside their space.
`timescale 1ns/1ps
module oag_mem_model #(
    parameter logic [15:0] Y_BASE = 16'h8000
) (
    input  wire logic        mclk_i,
    input  wire logic        x_rd_en_i,
    input  wire logic [15:0] x_rd_addr_i,
    input  wire logic        y_rd_en_i,
    input  wire logic [15:0] y_rd_addr_i,
    output logic [7:0]       x_cnt_o,
    output logic [7:0]       y_cnt_o,
    output logic             space_err_o
);
    initial {x_cnt_o, y_cnt_o, space_err_o} = '0;
    // A stray read is only flagged, since the block itself cannot refuse it.
    always @(posedge mclk_i) begin
        if (x_rd_en_i === 1'b1) begin
            x_cnt_o <= x_cnt_o + 8'h01;
            if (x_rd_addr_i >= Y_BASE) space_err_o <= 1'b1;
        end
        if (y_rd_en_i === 1'b1) begin
            y_cnt_o <= y_cnt_o + 8'h01;
            if (y_rd_addr_i < Y_BASE) space_err_o <= 1'b1;
        end
    end
endmodule : oag_mem_model

// ==== verification/testbench.sv ====
// Self-checking bench for operand address generation.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [2:0] c; logic [3:0] m, r; logic [15:0] l, f; logic e, mm; logic [15:0] x;} oag_row_t;
    logic        mclk_i, rst_n_i, vld, mdec, wbe, smem, dmem, xen, yen, done, err, serr;
    logic [2:0]  cls, xm, ym;
    logic [3:0]  sm, sr, dm, dr, xp, yp, wbr, dro, ofr = 4'h2;
    logic [7:0]  xc, yc;
    logic [15:0] lit, fa, wbd, sa, sd, da, xa, ya;
    int          err_count, tests_run;
    oag_row_t rows [11] = '{
        '{3'h0, 4'h0, 4'h0, 16'h0000, 16'h1234, 1'b0, 1'b1, 16'h1234},
        '{3'h0, 4'h2, 4'h1, 16'h0000, 16'h0000, 1'b0, 1'b1, 16'h0100},
        '{3'h0, 4'h6, 4'h1, 16'h0008, 16'h0000, 1'b0, 1'b1, 16'h0108},
        '{3'h0, 4'h5, 4'h1, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000},
        '{3'h2, 4'h5, 4'h1, 16'h0000, 16'h0000, 1'b0, 1'b1, 16'h0110},
        '{3'h2, 4'h0, 4'h0, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000},
        '{3'h1, 4'h1, 4'h1, 16'h0000, 16'h0000, 1'b0, 1'b0, 16'h0100},
        '{3'h1, 4'h7, 4'h0, 16'hFFA5, 16'h0000, 1'b0, 1'b0, 16'h00A5},
        '{3'h1, 4'h8, 4'h0, 16'hBEEF, 16'h0000, 1'b0, 1'b0, 16'hBEEF},
        '{3'h4, 4'hF, 4'h0, 16'h8001, 16'h0000, 1'b0, 1'b0, 16'h8001},
        '{3'h5, 4'hF, 4'h0, 16'hFFFF, 16'h0000, 1'b0, 1'b0, 16'h3FFF}};
    oag_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_valid_i(vld), .instr_class_i(cls), .src_mode_i(sm),
        .src_reg_i(sr), .dst_mode_i(dm), .dst_reg_i(dr), .offset_reg_i(ofr), .mod_dec_i(mdec), .literal_i(lit),
        .file_addr_i(fa), .x_ptr_i(xp), .x_pf_mode_i(xm), .y_ptr_i(yp), .y_pf_mode_i(ym), .wb_en_i(wbe),
        .wb_reg_i(wbr), .wb_data_i(wbd), .src_mem_o(smem), .src_addr_o(sa), .src_data_o(sd), .dst_mem_o(dmem),
        .dst_addr_o(da), .dst_reg_o(dro), .x_rd_en_o(xen), .x_rd_addr_o(xa), .y_rd_en_o(yen),
        .y_rd_addr_o(ya), .op_done_o(done), .mode_err_o(err));
    oag_mem_model i_mem (.mclk_i(mclk_i), .x_rd_en_i(xen), .x_rd_addr_i(xa), .y_rd_en_i(yen),
        .y_rd_addr_i(ya), .x_cnt_o(xc), .y_cnt_o(yc), .space_err_o(serr));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    // Tasks start and end at a falling edge; the strobe stays up so calls can run back to back.
    task automatic go(input logic [2:0] c, input logic [3:0] m, r, d, q, input logic [15:0] l, f);
        {vld, cls, sm, sr, dm, dr, lit, fa} = {1'b1, c, m, r, d, q, l, f};
        @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : go
    task automatic wr(input logic [3:0] r, input logic [15:0] d);
        {wbe, wbr, wbd} = {1'b1, r, d};
        @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : wr
    task automatic stop;
        {vld, wbe} = 2'b00;
        @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : stop
    task automatic mac(input logic [3:0] p, q, input logic [2:0] a, b, input logic e, input logic [15:0] ex, ey);
        {xp, yp, xm, ym} = {p, q, a, b};
        go(3'h3, 4'hF, 4'h0, 4'hF, 4'h0, 16'h0000, 16'h0000);
        chk(16'(err), 16'(e));
        if (!e) chk(xa, ex);
        if (!e && b != 3'h0) chk(ya, ey);
    endtask : mac
    initial begin
        repeat (3000) @(posedge mclk_i);
        err_count++;
        end_of_test();
    end
    initial begin
        {vld, mdec, wbe, rst_n_i, cls, xm, ym, err_count, tests_run} = '0;
        {sm, sr, dm, dr, xp, yp, wbr, lit, fa, wbd} = '0;
        repeat (12) @(negedge mclk_i);
        chk(16'({done, err, smem, xen}), 16'h0000);
        chk(sa | xa | sd, 16'h0000);
        rst_n_i = 1'b1;
        wr(4'h1, 16'h0100);
        wr(4'h2, 16'h0010);
        wr(4'h3, 16'h0200);
        wr(4'h8, 16'h0100);
        wr(4'h9, 16'h0300);
        wr(4'hA, 16'h8100);
        wr(4'hB, 16'h8000);
        wr(4'hE, 16'h0400);
        stop();
        foreach (rows[i]) begin
            go(rows[i].c, rows[i].m, rows[i].r, 4'hF, 4'h0, rows[i].l, rows[i].f);
            chk(16'({err, smem}), 16'({rows[i].e, rows[i].mm}));
            if (!rows[i].e) chk(rows[i].mm ? sa : sd, rows[i].x);
        end
        go(3'h1, 4'h3, 4'h3, 4'h1, 4'h4, 16'h0000, 16'h0000);
        chk(sa, 16'h0200);
        chk(16'({dmem, dro}), 16'h0004);
        go(3'h0, 4'h2, 4'h3, 4'hF, 4'h0, 16'h0000, 16'h0000);
        chk(sa, 16'h0202);
        mdec = 1'b1;
        go(3'h0, 4'h4, 4'h3, 4'hF, 4'h0, 16'h0000, 16'h0000);
        chk(sa, 16'h0200);
        mdec = 1'b0;
        ofr  = 4'h8;
        go(3'h1, 4'h5, 4'h1, 4'h5, 4'h3, 16'h0000, 16'h0000);
        ofr  = 4'h2;
        chk(sa, 16'h0200);
        chk(da, 16'h0300);
        go(3'h6, 4'hF, 4'h0, 4'hF, 4'h0, 16'h0000, 16'h0000);
        chk(16'(dro), 16'h000E);
        chk(sa, 16'h0400);
        go(3'h0, 4'h2, 4'hF, 4'hF, 4'h0, 16'h0000, 16'h0000);
        chk(sa, 16'h0400);
        go(3'h7, 4'hF, 4'h0, 4'hF, 4'h0, 16'h0000, 16'h0000);
        chk(16'({done, smem, dmem, xen}), 16'h0008);
        mac(4'h8, 4'hB, 3'h3, 3'h5, 1'b0, 16'h0100, 16'h8010);
        mac(4'h8, 4'hA, 3'h1, 3'h4, 1'b0, 16'h0104, 16'h8100);
        mac(4'h9, 4'hA, 3'h2, 3'h1, 1'b0, 16'h0300, 16'h8106);
        mac(4'h9, 4'hA, 3'h5, 3'h0, 1'b0, 16'h0312, 16'h0000);
        mac(4'h8, 4'hA, 3'h5, 3'h0, 1'b1, 16'h0000, 16'h0000);
        mac(4'hA, 4'hA, 3'h1, 3'h0, 1'b1, 16'h0000, 16'h0000);
        mac(4'h8, 4'h8, 3'h1, 3'h1, 1'b1, 16'h0000, 16'h0000);
        stop();
        chk({xc, yc}, 16'h0403);
        chk(16'(serr), 16'h0000);
        rst_n_i = 1'b0;
        stop();
        chk(sa | xa | sd, 16'h0000);
        rst_n_i = 1'b1;
        go(3'h0, 4'h6, 4'h9, 4'hF, 4'h0, 16'h0050, 16'h0000);
        chk(sa, 16'h0050);
        end_of_test();
    end
endmodule : testbench
